// ---- core/dvb_cnt_if.sv ----
// Control and count signals between the timing logic and one counter
`timescale 1ns/1ps
interface dvb_cnt_if #(
	parameter int W = 8
);
	logic          restart;
	logic          step;
	logic [W-1:0]  count;

	modport ctrl (output restart, output step, input count);
	modport cnt  (input restart, input step, output count);
endinterface

// ---- core/dvb_counter.sv ----
// Saturating up counter with synchronous restart
`timescale 1ns/1ps
module dvb_counter #(
	parameter int W = 8
) (
	input  wire logic  aclk,
	input  wire logic  aresetn,
	dvb_cnt_if.cnt     cnt_if
);
	logic [W-1:0]  count_q;
	logic [W-1:0]  count_d;

	// =====================================================================
	// Next count: restart wins over a step in the same cycle
	always_comb begin
		count_d = count_q;
		if (cnt_if.restart) begin
			count_d = '0;
		end else if (cnt_if.step && (count_q != {W{1'b1}})) begin
			count_d = count_q + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	assign cnt_if.count = count_q;

	// =====================================================================
	// Checks
	counter_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cnt_if.restart |=> (count_q == '0))
		else $error("counter did not restart");

	counter_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(cnt_if.step && !cnt_if.restart && (count_q != {W{1'b1}}))
		|=> (count_q == $past(count_q) + 1'b1))
		else $error("counter did not advance by one");

	counter_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!cnt_if.step && !cnt_if.restart) |=> $stable(count_q))
		else $error("counter moved without a step");

endmodule

// ---- core/dvb_pkg.sv ----
// Shared constants and types for the vertical sync and blanking offset block
package dvb_pkg;

	// =====================================================================
	// Register map (byte addresses on the AXI4-Lite slave)
	localparam int unsigned  ADDR_W     = 5;
	localparam logic [4:0]   OFF_VSYNC  = 5'h00;
	localparam logic [4:0]   OFF_BLANK  = 5'h04;
	localparam logic [4:0]   OFF_CTRL3  = 5'h08;
	localparam logic [4:0]   OFF_STATUS = 5'h0C;

	// =====================================================================
	// Reset values
	localparam logic [15:0]  VSYNC_RST  = 16'h0000;
	localparam logic [15:0]  BLANK_RST  = 16'h0000;
	localparam logic         VSOE_RST   = 1'b0;

	// =====================================================================
	// Field positions
	localparam int unsigned  FIELD_W    = 8;
	localparam int unsigned  WIDTH_LSB    = 8;
	localparam int unsigned  DELAY_LSB    = 0;
	localparam int unsigned  LINE_OFS_LSB = 8;
	localparam int unsigned  PIX_OFS_LSB  = 0;
	localparam int unsigned  VSOE_BIT   = 1;
	localparam int unsigned  STAT_LINE_LSB = 0;
	localparam int unsigned  STAT_PIX_LSB  = 16;
	localparam int unsigned  STAT_VS_BIT   = 24;
	localparam int unsigned  STAT_DE_BIT   = 25;

	// =====================================================================
	// Counters
	localparam int unsigned  LINE_W     = 10;
	localparam int unsigned  PIX_W      = 8;

	// =====================================================================
	// Bus responses
	localparam logic [1:0]   RESP_OKAY   = 2'h0;
	localparam logic [1:0]   RESP_SLVERR = 2'h2;

	typedef logic [LINE_W-1:0]  dvb_line_t;
	typedef logic [PIX_W-1:0]   dvb_pix_t;
	typedef logic [FIELD_W-1:0] dvb_field_t;

endpackage

// ---- core/dvb_top.sv ----
// Vertical sync and blanking offset timing with its AXI4-Lite register slave
//
// Functional notes
// - The vertical sync pulse lasts as many lines as the width field in bits 15-8 of vertical_sync_timing.
// - The vertical sync output moves only while vsync_output_enable is set, and is held low otherwise.
// - Vertical sync starts after as many lines from vertical blanking start as bits 7-0 of vertical_sync_timing.
// - The first displayed line comes as many lines after vertical blanking start as bits 15-8 of display_blanking_offsets.
// - The first displayed pixel comes as many pixel clocks after horizontal blanking start as bits 7-0 of display_blanking_offsets.
`timescale 1ns/1ps
module dvb_top (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [4:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [4:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic         pixel_clock_en,
	input  wire logic         hblank_start,
	input  wire logic         vblank_start,
	output logic              vsync_out,
	output logic              display_enable_out
);

	// =====================================================================
	// Write channel state
	logic         aw_held_q,  aw_held_d;
	logic [4:0]   awaddr_q,   awaddr_d;
	logic         w_held_q,   w_held_d;
	logic [31:0]  wdata_q,    wdata_d;
	logic [3:0]   wstrb_q,    wstrb_d;
	logic         awready_q,  awready_d;
	logic         wready_q,   wready_d;
	logic         bvalid_q,   bvalid_d;
	logic [1:0]   bresp_q,    bresp_d;
	logic         do_write;

	// =====================================================================
	// Read channel state
	logic         arready_q,  arready_d;
	logic         rvalid_q,   rvalid_d;
	logic [31:0]  rdata_q,    rdata_d;
	logic [1:0]   rresp_q,    rresp_d;
	logic [31:0]  rd_word;
	logic         rd_hit;

	// =====================================================================
	// Configuration registers
	logic [15:0]  vsync_cfg_q, vsync_cfg_d;
	logic [15:0]  blank_cfg_q, blank_cfg_d;
	logic         vsoe_q,      vsoe_d;

	// =====================================================================
	// Timing state
	logic                 vsync_q,  vsync_d;
	logic                 de_q,     de_d;
	dvb_pkg::dvb_line_t   line_cnt;
	dvb_pkg::dvb_pix_t    pix_cnt;
	dvb_pkg::dvb_field_t  vs_width;
	dvb_pkg::dvb_field_t  vs_delay;
	dvb_pkg::dvb_field_t  line_ofs;
	dvb_pkg::dvb_field_t  pix_ofs;
	dvb_pkg::dvb_line_t   vs_start;
	dvb_pkg::dvb_line_t   vs_end;

	dvb_cnt_if #(.W(dvb_pkg::LINE_W)) line_if ();
	dvb_cnt_if #(.W(dvb_pkg::PIX_W))  pix_if ();

	// =====================================================================
	// AXI4-Lite write: address and data taken in either order
	always_comb begin
		aw_held_d = aw_held_q;
		awaddr_d  = awaddr_q;
		w_held_d  = w_held_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		do_write  = aw_held_q && w_held_q && !bvalid_q;
		if (s_axi_awvalid && awready_q) begin
			aw_held_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_held_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (do_write) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			if (awaddr_q[4] == 1'b0) begin
				bresp_d = dvb_pkg::RESP_OKAY;
			end else begin
				bresp_d = dvb_pkg::RESP_SLVERR;
			end
		end
		awready_d = !aw_held_d && !bvalid_d;
		wready_d  = !w_held_d && !bvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			awaddr_q  <= 5'h00;
			w_held_q  <= 1'b0;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= dvb_pkg::RESP_OKAY;
		end else begin
			aw_held_q <= aw_held_d;
			awaddr_q  <= awaddr_d;
			w_held_q  <= w_held_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
		end
	end

	// =====================================================================
	// Register file; status word is read only and ignores writes
	always_comb begin
		vsync_cfg_d = vsync_cfg_q;
		blank_cfg_d = blank_cfg_q;
		vsoe_d      = vsoe_q;
		if (do_write) begin
			case ({awaddr_q[4:2], 2'b00})
				dvb_pkg::OFF_VSYNC: begin
					if (wstrb_q[0]) vsync_cfg_d[7:0]  = wdata_q[7:0];
					if (wstrb_q[1]) vsync_cfg_d[15:8] = wdata_q[15:8];
				end
				dvb_pkg::OFF_BLANK: begin
					if (wstrb_q[0]) blank_cfg_d[7:0]  = wdata_q[7:0];
					if (wstrb_q[1]) blank_cfg_d[15:8] = wdata_q[15:8];
				end
				dvb_pkg::OFF_CTRL3: begin
					if (wstrb_q[0]) vsoe_d = wdata_q[dvb_pkg::VSOE_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vsync_cfg_q <= dvb_pkg::VSYNC_RST;
			blank_cfg_q <= dvb_pkg::BLANK_RST;
			vsoe_q      <= dvb_pkg::VSOE_RST;
		end else begin
			vsync_cfg_q <= vsync_cfg_d;
			blank_cfg_q <= blank_cfg_d;
			vsoe_q      <= vsoe_d;
		end
	end

	// =====================================================================
	// AXI4-Lite read
	always_comb begin
		rd_word = 32'h00000000;
		rd_hit  = 1'b1;
		case ({s_axi_araddr[4:2], 2'b00})
			dvb_pkg::OFF_VSYNC:  rd_word[15:0] = vsync_cfg_q;
			dvb_pkg::OFF_BLANK:  rd_word[15:0] = blank_cfg_q;
			dvb_pkg::OFF_CTRL3:  rd_word[dvb_pkg::VSOE_BIT] = vsoe_q;
			dvb_pkg::OFF_STATUS: begin
				rd_word[dvb_pkg::STAT_LINE_LSB +: dvb_pkg::LINE_W] = line_cnt;
				rd_word[dvb_pkg::STAT_PIX_LSB +: dvb_pkg::PIX_W]   = pix_cnt;
				rd_word[dvb_pkg::STAT_VS_BIT] = vsync_q;
				rd_word[dvb_pkg::STAT_DE_BIT] = de_q;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rdata_d  = rd_word;
			rresp_d  = rd_hit ? dvb_pkg::RESP_OKAY : dvb_pkg::RESP_SLVERR;
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= dvb_pkg::RESP_OKAY;
		end else begin
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// =====================================================================
	// Line and pixel counters, each restarted by its blanking start
	assign line_if.restart = vblank_start;
	assign line_if.step    = hblank_start;
	assign pix_if.restart  = hblank_start;
	assign pix_if.step     = pixel_clock_en;
	assign line_cnt        = line_if.count;
	assign pix_cnt         = pix_if.count;

	dvb_counter #(.W(dvb_pkg::LINE_W)) u_line_cnt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.cnt_if  (line_if)
	);

	dvb_counter #(.W(dvb_pkg::PIX_W)) u_pix_cnt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.cnt_if  (pix_if)
	);

	// =====================================================================
	// Sync and display enable comparisons
	assign vs_width = vsync_cfg_q[dvb_pkg::WIDTH_LSB +: dvb_pkg::FIELD_W];
	assign vs_delay = vsync_cfg_q[dvb_pkg::DELAY_LSB +: dvb_pkg::FIELD_W];
	assign line_ofs = blank_cfg_q[dvb_pkg::LINE_OFS_LSB +: dvb_pkg::FIELD_W];
	assign pix_ofs  = blank_cfg_q[dvb_pkg::PIX_OFS_LSB +: dvb_pkg::FIELD_W];
	assign vs_start = {2'b00, vs_delay};
	assign vs_end   = vs_start + {2'b00, vs_width};

	always_comb begin
		// A zero width leaves the window empty, so no pulse at all
		vsync_d = vsoe_q
			&& (line_cnt >= vs_start)
			&& (line_cnt < vs_end);
		de_d    = (line_cnt >= {2'b00, line_ofs})
			&& (pix_cnt >= pix_ofs);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vsync_q <= 1'b0;
			de_q    <= 1'b0;
		end else begin
			vsync_q <= vsync_d;
			de_q    <= de_d;
		end
	end

	assign s_axi_awready      = awready_q;
	assign s_axi_wready       = wready_q;
	assign s_axi_bvalid       = bvalid_q;
	assign s_axi_bresp        = bresp_q;
	assign s_axi_arready      = arready_q;
	assign s_axi_rvalid       = rvalid_q;
	assign s_axi_rdata        = rdata_q;
	assign s_axi_rresp        = rresp_q;
	assign vsync_out          = vsync_q;
	assign display_enable_out = de_q;

	// =====================================================================
	// Checks
	vsync_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(vsync_q) |-> (($past(line_cnt) == $past(vs_end)) || ($past(line_cnt) == '0)
			|| !$past(vsoe_q) || ($past(vsync_cfg_q) != $past(vsync_cfg_q, 2))))
		else $error("vsync ended at the wrong line");

	vsync_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!$past(vsoe_q) |-> !vsync_q)
		else $error("vsync moved while its output was disabled");

	vsync_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(vsync_q) |-> (($past(line_cnt) == $past(vs_start)) || !$past(vsoe_q, 2)
			|| ($past(vsync_cfg_q) != $past(vsync_cfg_q, 2))))
		else $error("vsync started at the wrong line");

	vsync_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(vs_width) == '0) |-> !vsync_q)
		else $error("vsync pulsed with zero width");

	first_line_a: assert property (@(posedge aclk) disable iff (!aresetn)
		de_q |-> ($past(line_cnt) >= {2'b00, $past(line_ofs)}))
		else $error("display enabled before the first displayed line");

	first_pixel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		de_q |-> ($past(pix_cnt) >= $past(pix_ofs)))
		else $error("display enabled before the first displayed pixel");

	hblank_blank_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hblank_start ##1 (pix_ofs != '0) |=> !de_q)
		else $error("display enable not dropped after horizontal blanking start");

	bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(bvalid_q && !s_axi_bready) |=> (bvalid_q && $stable(bresp_q)))
		else $error("write response dropped before it was taken");

	rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(rvalid_q && !s_axi_rready) |=> (rvalid_q && $stable(rdata_q)))
		else $error("read data dropped before it was taken");

	write_lands_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && ({awaddr_q[4:2], 2'b00} == dvb_pkg::OFF_VSYNC) && (wstrb_q == 4'hF))
		|=> (vsync_cfg_q == $past(wdata_q[15:0])))
		else $error("vsync register write did not land");

endmodule

// ---- tb/dvb_panel.sv ----
// Panel side model: makes blanking and pixel pulses and records sync and display enable per line
`timescale 1ns/1ps
module dvb_panel #(
	parameter int NL  = 8,
	parameter int PIX = 6
) (
	input  wire logic         aclk,
	input  wire logic         go,
	input  wire logic         vsync_out,
	input  wire logic         display_enable_out,
	output logic              pixel_clock_en,
	output logic              hblank_start,
	output logic              vblank_start,
	output logic              done,
	output logic [NL:0]       vs_bits,
	output logic [NL:0][3:0]  de_first
);
	// =====================================================================
	// Frame generator
	// Pixel pulses are four cycles apart so each sample sees the settled result
	// of the previous pulse, two edges later
	initial begin
		int f;
		pixel_clock_en = 1'b0;
		hblank_start = 1'b0;
		vblank_start = 1'b0;
		done = 1'b0;
		vs_bits = '0;
		de_first = '1;
		forever begin
			do begin
				@(posedge aclk);
			end while (go !== 1'b1);
			done <= 1'b0;
			vblank_start <= 1'b1;
			@(posedge aclk);
			vblank_start <= 1'b0;
			repeat (4) @(posedge aclk);
			vs_bits[0] <= vsync_out;
			for (int k = 1; k <= NL; k++) begin
				hblank_start <= 1'b1;
				@(posedge aclk);
				hblank_start <= 1'b0;
				repeat (2) @(posedge aclk);
				f = 15;
				for (int j = 0; j < PIX; j++) begin
					if (display_enable_out === 1'b1 && f == 15) f = j;
					pixel_clock_en <= 1'b1;
					@(posedge aclk);
					pixel_clock_en <= 1'b0;
					repeat (3) @(posedge aclk);
				end
				if (display_enable_out === 1'b1 && f == 15) f = PIX;
				de_first[k] <= 4'(f);
				vs_bits[k] <= vsync_out;
			end
			done <= 1'b1;
		end
	end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the vertical sync and blanking offset block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
	localparam int NL  = 8;
	localparam int PIX = 6;
	logic              aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
	logic [4:0]        s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0]       s_axi_wdata = 32'h00000000, s_axi_rdata;
	logic [3:0]        s_axi_wstrb = 4'h0;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              pixel_clock_en, hblank_start, vblank_start, vsync_out;
	logic              display_enable_out, done;
	logic [NL:0]       vs_bits;
	logic [NL:0][3:0]  de_first;
	int                errors = 0, total_checks = 0, cyc = 0;

	dvb_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pixel_clock_en,
		.hblank_start, .vblank_start, .vsync_out, .display_enable_out);
	dvb_panel #(.NL(NL), .PIX(PIX)) u_panel (.aclk, .go, .vsync_out, .display_enable_out,
		.pixel_clock_en, .hblank_start, .vblank_start, .done, .vs_bits, .de_first);

	always #12.5 aclk = ~aclk;

	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			$display("MISMATCH %0t run did not finish", $time);
			final_report();
		end
	end

	// =====================================================================
	// Bus master
	task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, er)
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, ed)
		`CHK(s_axi_rresp, er)
	endtask

	// =====================================================================
	// Scenarios
	task automatic t_regs();
		rd(dvb_pkg::OFF_VSYNC, 32'h00000000, dvb_pkg::RESP_OKAY);
		rd(dvb_pkg::OFF_BLANK, 32'h00000000, dvb_pkg::RESP_OKAY);
		rd(dvb_pkg::OFF_CTRL3, 32'h00000000, dvb_pkg::RESP_OKAY);
		axw(dvb_pkg::OFF_VSYNC, 32'hABCD5A3C, 4'hF, dvb_pkg::RESP_OKAY);
		rd(dvb_pkg::OFF_VSYNC, 32'h00005A3C, dvb_pkg::RESP_OKAY);
		axw(dvb_pkg::OFF_VSYNC, 32'h0000C300, 4'h2, dvb_pkg::RESP_OKAY);
		rd(dvb_pkg::OFF_VSYNC, 32'h0000C33C, dvb_pkg::RESP_OKAY);
		axw(dvb_pkg::OFF_BLANK, 32'h00007E81, 4'hF, dvb_pkg::RESP_OKAY);
		rd(dvb_pkg::OFF_BLANK, 32'h00007E81, dvb_pkg::RESP_OKAY);
		axw(dvb_pkg::OFF_CTRL3, 32'hFFFFFFFF, 4'hF, dvb_pkg::RESP_OKAY);
		rd(dvb_pkg::OFF_CTRL3, 32'h00000002, dvb_pkg::RESP_OKAY);
		axw(5'h10, 32'h00000001, 4'hF, dvb_pkg::RESP_SLVERR);
		rd(5'h1C, 32'h00000000, dvb_pkg::RESP_SLVERR);
		axw(dvb_pkg::OFF_STATUS, 32'hFFFFFFFF, 4'hF, dvb_pkg::RESP_OKAY);
	endtask

	task automatic t_frame(input logic [7:0] vs_delay, input logic [7:0] vs_width,
		input logic [7:0] line_ofs, input logic [7:0] pix_ofs, input logic oe);
		logic       vs;
		logic [3:0] fe;
		logic       de;
		axw(dvb_pkg::OFF_VSYNC, {16'h0000, vs_width, vs_delay}, 4'hF, dvb_pkg::RESP_OKAY);
		axw(dvb_pkg::OFF_BLANK, {16'h0000, line_ofs, pix_ofs}, 4'hF, dvb_pkg::RESP_OKAY);
		axw(dvb_pkg::OFF_CTRL3, {30'h0, oe, 1'b0}, 4'h1, dvb_pkg::RESP_OKAY);
		@(posedge aclk);
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		while (done !== 1'b1) @(posedge aclk);
		vs = 1'b0;
		for (int k = 0; k <= NL; k++) begin
			vs = oe && k >= vs_delay && k < vs_delay + vs_width;
			fe = (k >= line_ofs) ? pix_ofs[3:0] : 4'hF;
			`CHK(vs_bits[k], vs)
			if (k > 0) `CHK(de_first[k], fe)
		end
		de = NL >= line_ofs && PIX >= pix_ofs;
		rd(dvb_pkg::OFF_STATUS, {6'h0, de, vs, 8'(PIX), 6'h0, 10'(NL)}, dvb_pkg::RESP_OKAY);
	endtask

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_frame(8'd1, 8'd2, 8'd3, 8'd2, 1'b0);
		t_frame(8'd0, 8'd1, 8'd0, 8'd0, 1'b1);
		t_frame(8'd2, 8'd3, 8'd8, 8'd6, 1'b1);
		t_frame(8'd5, 8'd8, 8'd1, 8'd5, 1'b1);
		final_report();
	end
endmodule
